// ---- rtl/bprs_defs.vh ----
// Timing and encoding constants for the board power and reset sequencer.
// Assumes a 20 MHz sequencer clock; included by the sequencer sources.
`ifndef BPRS_DEFS_VH
`define BPRS_DEFS_VH
`define BPRS_CLK_HZ        20000000
`define BPRS_WAIT_10MS     10
`define BPRS_WAIT_5MS      5
`define BPRS_WAIT_1MS      1
`define BPRS_CYC_PER_MS    (`BPRS_CLK_HZ / 1000)
`define BPRS_SYNC_W        12
`define BPRS_BOOT_W        16
`define BPRS_BOOT_RST      16'h0000
`endif

// ---- rtl/bprs_sequencer.v ----
// Board power and reset sequencer: rail enables, clock-generator control, processor resets.
// Assumes power-good and lock inputs are asynchronous pins; boot straps are static.
// Notes on behaviour
// RL1 - Hold all 1.8 V outputs toward processor low until unlock step.
// RL2 - Enable 2.5 V rail after aux 3.3 V stable 10 ms.
// RL3 - Enable adjustable core after 5 V and 2.5 V stable 5 ms.
// RL4 - Core controller starts fixed core rail 5 ms after its enable.
// RL5 - Enable 1.8 V I/O rail after fixed core stable 5 ms.
// RL6 - After 1.8 V stable 5 ms unlock outputs, release clockgen power-down.
// RL7 - Enable 1.5 V memory rail 5 ms after clockgen init starts.
// RL8 - Enable termination rail after 1.5 V stable 5 ms.
// RL9 - Release PCIe clock mux power-down when 1.5 V valid.
// RL10 - Enable PCIe clock mux outputs when termination rail valid.
// RL11 - Release warm reset after termination stable and 3 PLLs locked 5 ms.
// RL12 - Drive boot configuration onto general pins during warm reset release.
// RL13 - Release power-on reset 5 ms after warm reset release.
// RL14 - Release full reset 5 ms after power-on reset release.
// RL15 - Stop driving boot configuration 1 ms after full reset release.
// RL16 - On power failure assert full and power-on reset at once.
// RL17 - On power failure lock outputs and power down clockgens at once, then wait 5 ms.
// RL18 - Disable all main rails and PCIe clock mux controls in that same cycle.
// RL19 - System power valid high only while all supervised supplies valid.
// RL20 - Stability intervals counted on clock, restart if power-good drops.
// RL21 - Loss of an already valid power-good triggers power-down in any step from 2.5 V enable to run; adjustable core loss ignored in fixed core step.
`timescale 1ns/1ps
`include "bprs_defs.vh"
module bprs_sequencer #(
    parameter CYC_PER_MS = `BPRS_CYC_PER_MS,
    parameter BOOT_W     = `BPRS_BOOT_W
) (
    input  wire              ref_clk_in,
    input  wire              srst_in,
    input  wire              aux_3v3_supply_pg_in,
    input  wire              payload_12v_input_pg_in,
    input  wire              supply_5v_pg_in,
    input  wire              supply_2v5_pg_in,
    input  wire              adjustable_core_supply_pg_in,
    input  wire              fixed_core_supply_pg_in,
    input  wire              io_1v8_supply_pg_in,
    input  wire              memory_1v5_supply_pg_in,
    input  wire              memory_termination_supply_pg_in,
    input  wire [2:0]        clockgen_pll_lock_in,
    input  wire [BOOT_W-1:0] boot_config_in,
    output reg               supply_2v5_en_out,
    output reg               adjustable_core_supply_en_out,
    output reg               fixed_core_supply_en_out,
    output reg               io_1v8_supply_en_out,
    output reg               memory_1v5_supply_en_out,
    output reg               memory_termination_supply_en_out,
    output reg [2:0]         clockgen_powerdown_n_out,
    output reg               clockgen_init_start_out,
    output reg               pcie_mux_pd_n_out,
    output reg               pcie_mux_oe_n_out,
    output reg               io_unlock_out,
    output reg               proc_warm_reset_n_out,
    output reg               proc_power_on_reset_n_out,
    output reg               proc_full_reset_n_out,
    output reg               proc_misc_unlock_out,
    output reg [BOOT_W-1:0]  boot_gpio_out,
    output reg [BOOT_W-1:0]  boot_gpio_oe_out,
    output reg               system_power_valid_out
);
    localparam NS = `BPRS_SYNC_W;
    localparam [3:0] S_AUX    = 4'h0;
    localparam [3:0] S_2V5    = 4'h1;
    localparam [3:0] S_ACORE  = 4'h2;
    localparam [3:0] S_FCORE  = 4'h3;
    localparam [3:0] S_1V8    = 4'h4;
    localparam [3:0] S_CLKGEN = 4'h5;
    localparam [3:0] S_1V5    = 4'h6;
    localparam [3:0] S_TERM   = 4'h7;
    localparam [3:0] S_WARM   = 4'h8;
    localparam [3:0] S_POR    = 4'h9;
    localparam [3:0] S_FULL   = 4'ha;
    localparam [3:0] S_BOOT   = 4'hb;
    localparam [3:0] S_RUN    = 4'hc;
    localparam [3:0] S_PD_CLK = 4'hd;
    localparam [3:0] S_OFF    = 4'he;
    localparam [3:0] W10 = `BPRS_WAIT_10MS;
    localparam [3:0] W5  = `BPRS_WAIT_5MS;
    localparam [3:0] W1  = `BPRS_WAIT_1MS;

    // Three-stage synchronisers for all supervision pins
    wire [NS-1:0] raw_w;
    reg  [NS-1:0] s1_r;
    reg  [NS-1:0] s2_r;
    reg  [NS-1:0] s3_r;
    reg  [NS-1:0] pg_r;
    assign raw_w = {clockgen_pll_lock_in, memory_termination_supply_pg_in, memory_1v5_supply_pg_in,
                    io_1v8_supply_pg_in, fixed_core_supply_pg_in, adjustable_core_supply_pg_in,
                    supply_2v5_pg_in, supply_5v_pg_in, payload_12v_input_pg_in, aux_3v3_supply_pg_in};

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
            always @(posedge ref_clk_in) begin
                if (srst_in) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                    pg_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw_w[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        pg_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    wire pg_aux  = pg_r[0];
    wire pg_12v  = pg_r[1];
    wire pg_5v   = pg_r[2];
    wire pg_2v5  = pg_r[3];
    wire pg_acor = pg_r[4];
    wire pg_fcor = pg_r[5];
    wire pg_1v8  = pg_r[6];
    wire pg_1v5  = pg_r[7];
    wire pg_term = pg_r[8];
    wire pll_all = &pg_r[11:9];

    // Millisecond enable
    reg [31:0] div_r;
    reg        ms_tick_r;
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            div_r     <= 32'h0000_0000;
            ms_tick_r <= 1'b0;
        end else if (div_r >= CYC_PER_MS - 1) begin
            div_r     <= 32'h0000_0000;
            ms_tick_r <= 1'b1;
        end else begin
            div_r     <= div_r + 32'h0000_0001;
            ms_tick_r <= 1'b0;
        end
    end

    reg  [3:0] state_r;
    reg  [3:0] state_nxt;
    reg        tmr_run;
    reg  [3:0] tmr_tgt;
    wire       tmr_done;
    reg        st_new_r;

    bprs_timer #(
        .W(4)
    ) u_timer (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .run_in     (tmr_run),
        .ms_tick_in (ms_tick_r),
        .target_in  (tmr_tgt),
        .done_out   (tmr_done)
    );

    // Power-good set expected valid by the current step
    reg expect_ok;
    always @* begin
        expect_ok = 1'b1;
        if (state_r >= S_2V5 && state_r <= S_RUN) begin
            expect_ok = pg_aux & pg_12v & pg_5v;
        end
        if (state_r >= S_ACORE && state_r <= S_RUN) begin
            expect_ok = expect_ok & pg_2v5;
        end
        if (state_r >= S_1V8 && state_r <= S_RUN) begin
            expect_ok = expect_ok & pg_acor & pg_fcor;
        end
        if (state_r >= S_CLKGEN && state_r <= S_RUN) begin
            expect_ok = expect_ok & pg_1v8;
        end
        if (state_r >= S_TERM && state_r <= S_RUN) begin
            expect_ok = expect_ok & pg_1v5;
        end
        if (state_r >= S_WARM && state_r <= S_RUN) begin
            expect_ok = expect_ok & pg_term;
        end
    end

    // RL21 failure detect
    wire fail_w = (state_r >= S_2V5) && (state_r <= S_RUN) && !expect_ok;

    // RL20 stability timers
    always @* begin
        tmr_run = 1'b0;
        tmr_tgt = W5;
        case (state_r)
            S_AUX: begin
                tmr_run = pg_aux & pg_12v;
                tmr_tgt = W10;
            end
            S_2V5:    tmr_run = pg_5v & pg_2v5;
            S_ACORE:  tmr_run = pg_acor;
            S_FCORE:  tmr_run = pg_fcor;
            S_1V8:    tmr_run = pg_1v8;
            S_CLKGEN: tmr_run = !st_new_r;
            S_1V5:    tmr_run = pg_1v5;
            S_TERM:   tmr_run = pg_term & pll_all;
            S_WARM:   tmr_run = !st_new_r;
            S_POR:    tmr_run = !st_new_r;
            S_FULL: begin
                tmr_run = !st_new_r;
                tmr_tgt = W1;
            end
            S_PD_CLK: tmr_run = !st_new_r;
            default:  tmr_run = 1'b0;
        endcase
        // Timer cleared on entry so a stale done cannot chain steps
        if (st_new_r) begin
            tmr_run = 1'b0;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_AUX:    if (tmr_done) state_nxt = S_2V5;
            S_2V5:    if (tmr_done) state_nxt = S_ACORE;
            S_ACORE:  if (tmr_done) state_nxt = S_FCORE;
            S_FCORE:  if (tmr_done) state_nxt = S_1V8;
            S_1V8:    if (tmr_done) state_nxt = S_CLKGEN;
            S_CLKGEN: if (tmr_done) state_nxt = S_1V5;
            S_1V5:    if (tmr_done) state_nxt = S_TERM;
            S_TERM:   if (tmr_done) state_nxt = S_WARM;
            S_WARM:   if (tmr_done) state_nxt = S_POR;
            S_POR:    if (tmr_done) state_nxt = S_FULL;
            S_FULL:   if (tmr_done) state_nxt = S_BOOT;
            S_BOOT:   state_nxt = S_RUN;
            S_RUN:    state_nxt = S_RUN;
            S_PD_CLK: if (tmr_done) state_nxt = S_OFF;
            S_OFF:    if (pg_aux && pg_12v && !pg_2v5) state_nxt = S_AUX;
            default:  state_nxt = S_OFF;
        endcase
        // Done of the previous step still stands in the first cycle
        if (st_new_r) begin
            state_nxt = state_r;
        end
        if (fail_w) begin
            state_nxt = S_PD_CLK;
        end
    end

    wire up_w = (state_nxt <= S_RUN);

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_r                          <= S_AUX;
            st_new_r                         <= 1'b1;
            supply_2v5_en_out                <= 1'b0;
            adjustable_core_supply_en_out    <= 1'b0;
            fixed_core_supply_en_out         <= 1'b0;
            io_1v8_supply_en_out             <= 1'b0;
            memory_1v5_supply_en_out         <= 1'b0;
            memory_termination_supply_en_out <= 1'b0;
            clockgen_powerdown_n_out         <= 3'h0;
            clockgen_init_start_out          <= 1'b0;
            pcie_mux_pd_n_out                <= 1'b0;
            pcie_mux_oe_n_out                <= 1'b1;
            io_unlock_out                    <= 1'b0;
            proc_warm_reset_n_out            <= 1'b0;
            proc_power_on_reset_n_out        <= 1'b0;
            proc_full_reset_n_out            <= 1'b0;
            proc_misc_unlock_out             <= 1'b0;
            boot_gpio_out                    <= `BPRS_BOOT_RST;
            boot_gpio_oe_out                 <= {BOOT_W{1'b0}};
            system_power_valid_out           <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            st_new_r <= (state_nxt != state_r);
            // RL2 2v5 enable
            supply_2v5_en_out             <= up_w && state_nxt >= S_2V5;
            // RL3 adjustable core
            adjustable_core_supply_en_out <= up_w && state_nxt >= S_ACORE;
            // RL4 fixed core enable, controller delays start
            fixed_core_supply_en_out      <= up_w && state_nxt >= S_ACORE;
            // RL5 1v8 enable
            io_1v8_supply_en_out          <= up_w && state_nxt >= S_1V8;
            // RL1 RL6 RL17 unlock and clockgen power
            io_unlock_out                 <= up_w && state_nxt >= S_CLKGEN;
            clockgen_powerdown_n_out      <= {3{up_w && state_nxt >= S_CLKGEN}};
            clockgen_init_start_out       <= (state_nxt == S_CLKGEN) && (state_r != S_CLKGEN);
            // RL7 1v5 enable
            memory_1v5_supply_en_out      <= up_w && state_nxt >= S_1V5;
            // RL8 termination enable
            memory_termination_supply_en_out <= up_w && state_nxt >= S_TERM;
            // RL9 RL10 RL18 PCIe mux control
            pcie_mux_pd_n_out             <= up_w && state_nxt >= S_1V5 && pg_1v5;
            pcie_mux_oe_n_out             <= !(up_w && state_nxt >= S_TERM && pg_term);
            // RL11 warm reset release
            proc_warm_reset_n_out         <= up_w && state_nxt >= S_WARM;
            proc_misc_unlock_out          <= up_w && state_nxt >= S_WARM;
            // RL13 RL16 power-on reset
            proc_power_on_reset_n_out     <= up_w && state_nxt >= S_POR;
            // RL14 RL16 full reset
            proc_full_reset_n_out         <= up_w && state_nxt >= S_FULL;
            // RL12 RL15 boot config drive
            boot_gpio_out                 <= boot_config_in;
            boot_gpio_oe_out              <= {BOOT_W{up_w && state_nxt >= S_WARM && state_nxt <= S_FULL}};
            // RL19 system power valid
            system_power_valid_out        <= (state_r >= S_WARM) && (state_r <= S_RUN) && expect_ok &&
                                             pg_term && up_w;
        end
    end
endmodule

// ---- rtl/bprs_timer.v ----
// Millisecond timer for the sequencer: counts whole milliseconds while run is high.
// Assumes a one-cycle ms_tick enable from the main module's divider.
`timescale 1ns/1ps
module bprs_timer #(
    parameter W = 4
) (
    input  wire         ref_clk_in,
    input  wire         srst_in,
    input  wire         run_in,
    input  wire         ms_tick_in,
    input  wire [W-1:0] target_in,
    output reg          done_out
);
    reg [W-1:0] cnt_r;

    // RL20 restart on drop
    always @(posedge ref_clk_in) begin
        if (srst_in || !run_in) begin
            cnt_r    <= {W{1'b0}};
            done_out <= 1'b0;
        end else if (ms_tick_in && !done_out) begin
            // First tick may be partial, so target plus one ticks
            if (cnt_r >= target_in) begin
                done_out <= 1'b1;
            end
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule

// ---- test/board_power_reset_sequencer_bench.sv ----
// Self-checking bench: power-up, glitch, failures from run and mid-sequence.
// Assumes a millisecond of MS cycles and the supply model on the far side.
`timescale 1ns/1ps
module board_power_reset_sequencer_bench;
    localparam MS = 20, SL = 10, RS = 30, FX = 100;
    logic ref_clk_in = 0, srst_in = 1, aux_pg = 0, p12_pg = 0, v5_pg = 0;
    logic [15:0] boot_cfg = 16'h0000;
    logic [8:0] kill = 9'h000;
    wire [8:0] good;
    wire s2v5, sadj, sfix, s1v8, s1v5, sterm, init_p, mpd, moe, unl, warm, por, full, misc, spv;
    wire [2:0] pdn;
    wire [15:0] gpio, goe;
    wire [12:0] ev = {full && goe == 0, full, por, warm, ~moe, sterm, mpd, s1v5, unl, s1v8, sfix, sadj, s2v5};
    int miscompares = 0, cmp_count = 0, cyc = 0, tf;
    int t [13];
    bprs_sequencer #(.CYC_PER_MS(MS)) DUT (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .aux_3v3_supply_pg_in(aux_pg), .payload_12v_input_pg_in(p12_pg), .supply_5v_pg_in(v5_pg),
        .supply_2v5_pg_in(good[0]), .adjustable_core_supply_pg_in(good[1]), .fixed_core_supply_pg_in(good[2]),
        .io_1v8_supply_pg_in(good[3]), .memory_1v5_supply_pg_in(good[4]),
        .memory_termination_supply_pg_in(good[5]), .clockgen_pll_lock_in(good[8:6]), .boot_config_in(boot_cfg),
        .supply_2v5_en_out(s2v5), .adjustable_core_supply_en_out(sadj), .fixed_core_supply_en_out(sfix),
        .io_1v8_supply_en_out(s1v8), .memory_1v5_supply_en_out(s1v5), .memory_termination_supply_en_out(sterm),
        .clockgen_powerdown_n_out(pdn), .clockgen_init_start_out(init_p), .pcie_mux_pd_n_out(mpd),
        .pcie_mux_oe_n_out(moe), .io_unlock_out(unl), .proc_warm_reset_n_out(warm),
        .proc_power_on_reset_n_out(por), .proc_full_reset_n_out(full), .proc_misc_unlock_out(misc),
        .boot_gpio_out(gpio), .boot_gpio_oe_out(goe), .system_power_valid_out(spv));
    bprs_supply_model #(.RISE(RS), .FIXED(FX)) u_model (.clk_in(ref_clk_in),
        .on_in({pdn, sterm, s1v5, s1v8, sfix, sadj, s2v5}), .kill_in(kill), .good_out(good));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s exp %0h seen %0h", what, exp, seen);
        end
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task gap(input int e, input int c, input int lo, input int hi);
        chk(t[e] >= c + lo * MS && t[e] <= c + hi, 1, $sformatf("step %0d", e));
    endtask
    task wait_ev(input int e, input int lim);
        for (int n = 0; t[e] < 0 && n < lim; n++) @(negedge ref_clk_in);
        if (t[e] < 0) begin
            miscompares++;
            finish_test();
        end
    endtask
    task up_check(input int c0, input int lo0, input int hi0);
        wait_ev(12, 150 * MS);
        gap(0, c0, lo0, hi0);
        chk(t[2], t[1], "fixed en");
        gap(1, t[0] + RS, 5, 99 * MS);
        gap(3, t[2] + FX, 5, 99 * MS);
        gap(4, t[3] + RS, 5, 99 * MS);
        gap(5, t[4], 5, 6 * MS + SL);
        gap(6, t[5] + RS, 0, SL);
        gap(7, t[5] + RS, 5, 99 * MS);
        gap(8, t[7] + RS, 0, SL);
        gap(9, t[7] + RS, 5, 99 * MS);
        gap(10, t[9], 5, 6 * MS + SL);
        gap(11, t[10], 5, 6 * MS + SL);
        gap(12, t[11], 1, 2 * MS + SL);
        chk({pdn, misc, spv}, 5'h1f, "run");
    endtask
    task fail_check();
        int n;
        for (n = 0; s2v5 && n < 12; n++) @(negedge ref_clk_in);
        chk(n < 9, 1, "fail delay");
        chk({s2v5, sadj, sfix, s1v8, s1v5, sterm, pdn, unl, mpd, moe, warm, por, full, |goe, spv}, 17'h20, "off");
        tf = cyc;
        foreach (t[i]) t[i] = -1;
    endtask
    initial forever #25 ref_clk_in = ~ref_clk_in;
    always @(negedge ref_clk_in) begin
        cyc++;
        for (int i = 0; i < 13; i++) if (t[i] < 0 && ev[i]) t[i] = cyc;
        if (!s1v8) chk(unl, 0, "locked");
        if (warm && !full) chk({|goe, gpio}, {1'b1, boot_cfg}, "boot");
        chk(init_p, unl && t[4] == cyc, "init");
    end
    initial begin
        void'($urandom(32711));
        foreach (t[i]) t[i] = -1;
        repeat (10) @(negedge ref_clk_in);
        srst_in = 0;
        boot_cfg = $urandom;
        {aux_pg, p12_pg, v5_pg} = 3'h7;
        repeat (5 * MS) @(negedge ref_clk_in);
        aux_pg = 0;
        repeat (10) @(negedge ref_clk_in);
        aux_pg = 1;
        up_check(cyc, 10, 11 * MS + SL);
        $display("test 1 power-up with aux glitch done");
        p12_pg = 0;
        fail_check();
        p12_pg = 1;
        boot_cfg = $urandom;
        wait_ev(3, 80 * MS);
        gap(0, tf, 15, 17 * MS + SL);
        kill[$urandom_range(2, 0)] = 1;
        fail_check();
        kill = 9'h000;
        $display("test 2 failure in run and mid-sequence done");
        up_check(tf, 15, 17 * MS + SL);
        kill[$urandom_range(5, 0)] = 1;
        fail_check();
        $display("test 3 restart and rail loss done");
        finish_test();
    end
endmodule
bind bprs_sequencer bprs_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (.*);

// ---- test/bprs_monitor.sv ----
// Concurrent checks on the board power sequencer ports.
// Assumes a bind onto bprs_sequencer with ports joined by name.
`timescale 1ns/1ps
module bprs_monitor #(
    parameter CYC_PER_MS = 20
) (
    input wire        ref_clk_in,
    input wire        srst_in,
    input wire        aux_3v3_supply_pg_in,
    input wire        payload_12v_input_pg_in,
    input wire        memory_1v5_supply_pg_in,
    input wire        memory_termination_supply_pg_in,
    input wire [2:0]  clockgen_pll_lock_in,
    input wire [15:0] boot_config_in,
    input wire        supply_2v5_en_out,
    input wire        io_1v8_supply_en_out,
    input wire        memory_1v5_supply_en_out,
    input wire [2:0]  clockgen_powerdown_n_out,
    input wire        pcie_mux_pd_n_out,
    input wire        pcie_mux_oe_n_out,
    input wire        io_unlock_out,
    input wire        proc_warm_reset_n_out,
    input wire        proc_power_on_reset_n_out,
    input wire        proc_full_reset_n_out,
    input wire [15:0] boot_gpio_out,
    input wire [15:0] boot_gpio_oe_out
);
    localparam int C = CYC_PER_MS;
    int aux_c_r, warm_c_r, lock_c_r;
    // Cycles each condition has held without a break
    always @(posedge ref_clk_in) begin
        aux_c_r  <= (srst_in || !(aux_3v3_supply_pg_in && payload_12v_input_pg_in)) ? 0 : aux_c_r + 1;
        warm_c_r <= (srst_in || !proc_warm_reset_n_out) ? 0 : warm_c_r + 1;
        lock_c_r <= (srst_in || !(memory_termination_supply_pg_in && &clockgen_pll_lock_in)) ? 0 : lock_c_r + 1;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    a_aux_wait_2v5: assert property ($rose(supply_2v5_en_out) |-> aux_c_r >= 10 * C - 1)
        else $error("2v5 rail enabled too early");
    a_unlock_after_io: assert property ($rose(io_unlock_out) |-> io_1v8_supply_en_out
        && clockgen_powerdown_n_out == 3'h7) else $error("unlock out of order");
    a_mux_pd_1v5: assert property ($rose(pcie_mux_pd_n_out) |-> memory_1v5_supply_pg_in)
        else $error("mux power-up without 1v5");
    a_mux_oe_term: assert property ($fell(pcie_mux_oe_n_out) |-> memory_termination_supply_pg_in)
        else $error("mux outputs without termination");
    a_warm_after_lock: assert property ($rose(proc_warm_reset_n_out) |-> lock_c_r >= 5 * C - 1)
        else $error("warm release too early");
    a_boot_value_drive: assert property (|boot_gpio_oe_out |-> boot_gpio_out == boot_config_in)
        else $error("boot value wrong");
    a_por_after_warm: assert property ($rose(proc_power_on_reset_n_out) |->
        warm_c_r >= 5 * C - 1 && warm_c_r <= 6 * C + 8) else $error("por release timing");
    a_fail_resets_low: assert property ($fell(payload_12v_input_pg_in) && proc_full_reset_n_out
        |-> ##[1:8] !proc_full_reset_n_out && !proc_power_on_reset_n_out) else $error("no reset on failure");
    a_off_all_together: assert property ($fell(supply_2v5_en_out) |-> !io_1v8_supply_en_out
        && !memory_1v5_supply_en_out && clockgen_powerdown_n_out == 3'h0 && !io_unlock_out
        && !pcie_mux_pd_n_out && pcie_mux_oe_n_out && !proc_power_on_reset_n_out) else $error("partial shutdown");
    cover property ($rose(proc_full_reset_n_out));
    cover property ($fell(supply_2v5_en_out));
    cover property ($fell(|boot_gpio_oe_out) && proc_full_reset_n_out);
endmodule

// ---- test/bprs_supply_model.sv ----
// Regulators and clock generators: good follows enable after a delay.
// Assumes bit 2 is the fixed core rail; kill_in makes a rail fail.
`timescale 1ns/1ps
module bprs_supply_model #(
    parameter RISE  = 30,
    parameter FIXED = 100
) (
    input  wire       clk_in,
    input  wire [8:0] on_in,
    input  wire [8:0] kill_in,
    output reg  [8:0] good_out
);
    int cnt [9];
    initial good_out = 9'h000;
    always @(posedge clk_in) begin
        for (int i = 0; i < 9; i++) begin
            cnt[i] <= (on_in[i] && !kill_in[i]) ? cnt[i] + 1 : 0;
            good_out[i] <= on_in[i] && !kill_in[i] && cnt[i] >= (i == 2 ? FIXED : RISE);
        end
    end
endmodule
